// ---- arc_breaker_model.sv ----
// Purpose: Two line breakers answering close commands
// Assumes: Trip from the bench opens a breaker at once
// Notes:   Close needs dly cycles of held command
`timescale 1ns/1ps
module arc_breaker_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [1:0] trip,
    input  wire logic [1:0] cls,
    input  wire logic [3:0] dly,
    output logic      [1:0] closed
);
    logic [3:0] cnt [2];
    always @(posedge mclk) begin
        for (int i = 0; i < 2; i++) begin
            cnt[i] <= (rst || !cls[i] || closed[i]) ? 4'h0 : cnt[i] + 4'h1;
            if (rst) closed[i] <= 1'b1;
            else if (trip[i]) closed[i] <= 1'b0;
            else if (cnt[i] == dly) closed[i] <= 1'b1;
        end
    end
endmodule // arc_breaker_model

// ---- arc_regs.vh ----
// Purpose: Constants for the autoreclose sequencer: offsets, fields, defaults, timing
// Assumes: 100 MHz mclk, settings counted in 10 ms ticks
// Notes:   Definitions only
`ifndef ARC_REGS_VH
`define ARC_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets (byte addresses)
`define ARC_ADDR_W          8
`define ARC_OFS_CTRL        8'h00
`define ARC_OFS_SET_BASE    8'h04
`define ARC_OFS_STATUS      8'h20
`define ARC_NUM_SET         7

// Setting slots, offset = base + 4 * slot
`define ARC_SET_SP_DEAD     3'h0
`define ARC_SET_DEAD1       3'h1
`define ARC_SET_DEAD2       3'h2
`define ARC_SET_EXTEND      3'h3
`define ARC_SET_RESET       3'h4
`define ARC_SET_INCOMPLETE  3'h5
`define ARC_SET_TRANSFER    3'h6
`define ARC_SET_NONE        3'h7

////////////////////////////////////////////////////////////////////////////////
// Control fields
`define ARC_CTRL_EN_BIT     0
`define ARC_CTRL_PROG_LSB   1
`define ARC_CTRL_PROG_MSB   2
`define ARC_CTRL_SHOTS_BIT  3
`define ARC_CTRL_SEQ_LSB    4
`define ARC_CTRL_SEQ_MSB    5
`define ARC_CTRL_RST        6'h08

// Reclose programs
`define ARC_PROG_1AND3      2'h0
`define ARC_PROG_1POLE      2'h1
`define ARC_PROG_3POLE_A    2'h2
`define ARC_PROG_3POLE_B    2'h3

// Breaker sequences
`define ARC_SEQ_BKR1        2'h0
`define ARC_SEQ_BKR2        2'h1
`define ARC_SEQ_BOTH        2'h2
`define ARC_SEQ_1THEN2      2'h3

////////////////////////////////////////////////////////////////////////////////
// Setting defaults in 10 ms ticks
`define ARC_RST_SP_DEAD     16'h0064
`define ARC_RST_DEAD1       16'h0032
`define ARC_RST_DEAD2       16'h0078
`define ARC_RST_EXTEND      16'h0032
`define ARC_RST_RESET       16'h1770
`define ARC_RST_INCOMPLETE  16'h03e8
`define ARC_RST_TRANSFER    16'h0064

////////////////////////////////////////////////////////////////////////////////
// Status fields
`define ARC_STAT_STATE_LSB  0
`define ARC_STAT_STATE_MSB  2
`define ARC_STAT_SHOT_LSB   4
`define ARC_STAT_SHOT_MSB   5
`define ARC_STAT_RIP_BIT    8
`define ARC_STAT_FORCE_BIT  9
`define ARC_STAT_CLS1_BIT   10
`define ARC_STAT_CLS2_BIT   11
`define ARC_STAT_LO_BIT     12

////////////////////////////////////////////////////////////////////////////////
// Timing
`define ARC_CLK_KHZ         100000
`define ARC_TICK_MS         10
`define ARC_FORCE_DELAY_MS  8
`define ARC_TICK_CYCLES     (`ARC_TICK_MS * `ARC_CLK_KHZ)
`define ARC_FORCE_CYCLES    (`ARC_FORCE_DELAY_MS * `ARC_CLK_KHZ)

`endif

// ---- arc_seq_monitor.sv ----
// Purpose: Port checks for the autoreclose sequencer
// Assumes: Pins synced by two flops
// Notes:   Bound to arc_sequencer
`timescale 1ns/1ps
module arc_seq_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic single_pole_initiate,
    input wire logic three_pole_initiate,
    input wire logic delayed_three_pole_initiate,
    input wire logic reset_input,
    input wire logic reclose_in_progress,
    input wire logic force_three_pole_trip,
    input wire logic close_breaker_one_cmd,
    input wire logic close_breaker_two_cmd,
    input wire logic lockout_state
);
    wire ini = single_pole_initiate | three_pole_initiate | delayed_three_pole_initiate;
    wire rip = reclose_in_progress;
    wire lo  = lockout_state;
    wire cls = close_breaker_one_cmd | close_breaker_two_cmd;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_rip_lo_excl: assert property (!(rip && lo))
        else $error("rip and lockout together");
    chk_rip_cause: assert property ($rose(rip) |-> $past(ini, 2))
        else $error("rip without initiate");
    chk_rip_holds: assert property ($rose(rip) |=> rip)
        else $error("rip too short");
    chk_rip_ends: assert property ($fell(rip) |-> ##[0:2] (cls || lo))
        else $error("rip ended without close or lockout");
    chk_cls_no_rip: assert property ($rose(cls) |-> !rip)
        else $error("close during rip");
    chk_lo_no_cls: assert property (lo [*2] |-> !cls)
        else $error("close held in lockout");
    chk_force_drop: assert property ($fell(force_three_pole_trip) |-> !rip)
        else $error("force dropped in rip");
    chk_lo_exit: assert property ($fell(lo) |-> $past(reset_input, 2))
        else $error("lockout left without reset");
endmodule // arc_seq_monitor
////////////////////////////////////////////////////////////
bind arc_sequencer arc_seq_monitor i_mon (.mclk, .rst, .single_pole_initiate,
    .three_pole_initiate, .delayed_three_pole_initiate, .reset_input, .reclose_in_progress,
    .force_three_pole_trip, .close_breaker_one_cmd, .close_breaker_two_cmd, .lockout_state);

// ---- arc_sequencer.v ----
// Purpose: Autoreclose sequencer for one or two line breakers
// Assumes: Pin inputs asynchronous; register port on mclk
// Notes:   Timers count 10 ms ticks; states DISABLED, RESET, DEAD, CLOSE, LOCKOUT
// Contract
// [RULE1] Four programs: one-and-three-pole, single-pole, three-pole A, three-pole B.
// [RULE2] Shot limit setting takes only one or two.
// [RULE3] Second shot is always three-pole, timed by second three-pole dead time.
// [RULE4] Dead and delay timers span 0 to 655.35 s in 0.01 s steps.
// [RULE5] Reset time spans 0 to 655.35 s, default sixty seconds.
// [RULE6] Close goes to one breaker, both together, or both in sequence.
// [RULE7] In sequence, trip logic trips and recloses second breaker three-pole.
// [RULE8] Simultaneous reclose: trip logic trips both breakers per program.
// [RULE9] Protection supplies initiate from its single- or three-pole trip.
// [RULE10] Disabled function ignores all initiates.
// [RULE11] Reset state accepts initiates and holds shot counter at zero.
// [RULE12] Reclose in progress from initiate until cycle completes.
// [RULE13] Lockout ignores initiates until reset input.
// [RULE14] Shot limit one: further initiate after reclose goes to lockout.
// [RULE15] Three-pole programs assert force three-pole trip.
// [RULE16] One-and-three-pole program picks dead timer by initiate kind.
// [RULE17] Single-pole program: single-phase uses single-pole timer, else lockout.
// [RULE18] Program A: single-phase only, first three-pole timer; multiphase locks out.
// [RULE19] Program B: any fault, first timer; delayed initiate uses second timer.
// [RULE20] Reclose in progress held until close command or lockout.
// [RULE21] Force three-pole 8 ms after single-pole dead start, held to reset/lockout.
// [RULE22] Reset timer from close; expiry with breaker closed returns to reset.
// [RULE23] Incomplete-sequence timer from initiate; expiry without close means lockout.
// [RULE24] Extension input during first dead time adds the extension interval; code adds it to the first three-pole dead time only.
// [RULE25] All timers count whole 10 ms ticks up to their setting.
`timescale 1ns/1ps
`include "arc_regs.vh"

module arc_sequencer #(
    parameter TICK_CYCLES  = `ARC_TICK_CYCLES,
    parameter FORCE_CYCLES = `ARC_FORCE_CYCLES
) (
    input  wire                   mclk,
    input  wire                   rst,
    input  wire [`ARC_ADDR_W-1:0] reg_addr,
    input  wire [31:0]            reg_wdata,
    input  wire                   reg_wr,
    input  wire                   reg_rd,
    output reg  [31:0]            reg_rdata,
    input  wire                   single_pole_initiate,
    input  wire                   three_pole_initiate,
    input  wire                   delayed_three_pole_initiate,
    input  wire                   multiphase_fault_input,
    input  wire                   dead_time_extension_input,
    input  wire                   reset_input,
    input  wire                   breaker_closed_input,
    input  wire                   breaker_two_closed_input,
    input  wire                   scheme_block_input,
    output wire                   reclose_in_progress,
    output reg                    force_three_pole_trip,
    output reg                    close_breaker_one_cmd,
    output reg                    close_breaker_two_cmd,
    output wire                   lockout_state
);
    localparam [2:0] ST_DISABLED = 3'h0;
    localparam [2:0] ST_RESET    = 3'h1;
    localparam [2:0] ST_DEAD     = 3'h2;
    localparam [2:0] ST_CLOSE    = 3'h3;
    localparam [2:0] ST_LOCKOUT  = 3'h4;

    localparam [1:0] SEL_SP = 2'h0;
    localparam [1:0] SEL_D1 = 2'h1;
    localparam [1:0] SEL_D2 = 2'h2;

    localparam [19:0] FORCE_LAST = FORCE_CYCLES[19:0] - 20'h0_0001;

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers
    function [2:0] set_index;
        input [`ARC_ADDR_W-1:0] addr;
        reg   [`ARC_ADDR_W-1:0] rel;
        begin
            rel = addr - `ARC_OFS_SET_BASE;
            if (addr >= `ARC_OFS_SET_BASE && addr < `ARC_OFS_STATUS && rel[1:0] == 2'h0)
                set_index = rel[4:2];
            else
                set_index = `ARC_SET_NONE;
        end
    endfunction

    function [15:0] set_default;
        input [2:0] idx;
        begin
            case (idx)
                `ARC_SET_SP_DEAD:    set_default = `ARC_RST_SP_DEAD;
                `ARC_SET_DEAD1:      set_default = `ARC_RST_DEAD1;
                `ARC_SET_DEAD2:      set_default = `ARC_RST_DEAD2;
                `ARC_SET_EXTEND:     set_default = `ARC_RST_EXTEND;
                `ARC_SET_RESET:      set_default = `ARC_RST_RESET;
                `ARC_SET_INCOMPLETE: set_default = `ARC_RST_INCOMPLETE;
                default:             set_default = `ARC_RST_TRANSFER;
            endcase
        end
    endfunction

    // Returns {lockout, dead select} for the first shot
    function [2:0] first_shot;
        input [1:0] prog;
        input       sp;
        input       tp;
        input       dtp;
        input       mp;
        begin
            case (prog)
                `ARC_PROG_1AND3:                                      // [RULE16]
                    first_shot = dtp ? {1'b0, SEL_D2} :
                                 (tp | mp) ? {1'b0, SEL_D1} : {1'b0, SEL_SP};
                `ARC_PROG_1POLE:                                      // [RULE17]
                    first_shot = (sp & !mp) ? {1'b0, SEL_SP} : {1'b1, SEL_SP};
                `ARC_PROG_3POLE_A:                                    // [RULE18]
                    first_shot = mp ? {1'b1, SEL_D1} : {1'b0, SEL_D1};
                default:                                              // [RULE19]
                    first_shot = dtp ? {1'b0, SEL_D2} : {1'b0, SEL_D1};
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg [8:0] sync1_reg;
    reg [8:0] sync2_reg;
    reg       init_prev_reg;

    always @(posedge mclk) begin
        if (rst) begin
            sync1_reg <= 9'h000;
            sync2_reg <= 9'h000;
        end else begin
            sync1_reg <= {scheme_block_input, breaker_two_closed_input, breaker_closed_input,
                          reset_input, dead_time_extension_input, multiphase_fault_input,
                          delayed_three_pole_initiate, three_pole_initiate,
                          single_pole_initiate};
            sync2_reg <= sync1_reg;
        end
    end

    wire sp_s    = sync2_reg[0];
    wire tp_s    = sync2_reg[1];
    wire dtp_s   = sync2_reg[2];
    wire mp_s    = sync2_reg[3];
    wire ext_s   = sync2_reg[4];
    wire rstin_s = sync2_reg[5];
    wire bkr1_s  = sync2_reg[6];
    wire bkr2_s  = sync2_reg[7];
    wire blk_s   = sync2_reg[8];

    wire init_lvl  = sp_s | tp_s | dtp_s;
    wire init_edge = init_lvl & !init_prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [5:0]  ctrl_reg;
    reg [15:0] set_reg [0:`ARC_NUM_SET-1];
    reg [2:0]  state_reg;
    reg [2:0]  state_next;
    reg [1:0]  sel_reg;
    reg [1:0]  sel_next;
    reg [1:0]  shot_reg;
    reg [1:0]  shot_next;
    reg        ext_reg;
    reg        xfer_done_reg;
    reg        force_latch_reg;
    reg [19:0] force_cnt_reg;
    integer    i;

    wire       enable    = ctrl_reg[`ARC_CTRL_EN_BIT];
    wire [1:0] prog      = ctrl_reg[`ARC_CTRL_PROG_MSB:`ARC_CTRL_PROG_LSB];
    wire [1:0] seq       = ctrl_reg[`ARC_CTRL_SEQ_MSB:`ARC_CTRL_SEQ_LSB];
    wire [1:0] shot_lim  = ctrl_reg[`ARC_CTRL_SHOTS_BIT] ? 2'h2 : 2'h1;   // [RULE2]
    wire [2:0] wr_idx    = set_index(reg_addr);

    always @(posedge mclk) begin
        if (rst) begin
            ctrl_reg  <= `ARC_CTRL_RST;
            reg_rdata <= 32'h0000_0000;
            for (i = 0; i < `ARC_NUM_SET; i = i + 1) begin
                set_reg[i] <= set_default(i[2:0]);                   // [RULE4] [RULE5]
            end
        end else begin
            if (reg_wr && reg_addr == `ARC_OFS_CTRL) begin
                ctrl_reg <= reg_wdata[5:0];                           // [RULE1]
            end
            if (reg_wr && wr_idx != `ARC_SET_NONE) begin
                set_reg[wr_idx] <= reg_wdata[15:0];
            end
            if (reg_rd) begin
                if (reg_addr == `ARC_OFS_CTRL)
                    reg_rdata <= {26'h000_0000, ctrl_reg};
                else if (wr_idx != `ARC_SET_NONE)
                    reg_rdata <= {16'h0000, set_reg[wr_idx]};
                else if (reg_addr == `ARC_OFS_STATUS)
                    reg_rdata <= {19'h0_0000, lockout_state, close_breaker_two_cmd,
                                  close_breaker_one_cmd, force_three_pole_trip,
                                  reclose_in_progress, 2'h0, shot_reg, 1'b0, state_reg};
                else
                    reg_rdata <= 32'h0000_0000;
            end else begin
                reg_rdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timers: 0 dead, 1 incomplete, 2 reset, 3 transfer
    wire        tick;
    wire [3:0]  tmr_run;
    wire [3:0]  tmr_exp;
    wire [67:0] tmr_set;
    reg  [16:0] dead_set;

    always @* begin
        case (sel_reg)
            SEL_SP:  dead_set = {1'b0, set_reg[`ARC_SET_SP_DEAD]};
            SEL_D1:  dead_set = {1'b0, set_reg[`ARC_SET_DEAD1]} +
                                (ext_reg ? {1'b0, set_reg[`ARC_SET_EXTEND]}
                                         : 17'h0_0000);            // [RULE24]
            default: dead_set = {1'b0, set_reg[`ARC_SET_DEAD2]};
        endcase
    end

    assign tmr_run[0] = (state_reg == ST_DEAD);
    assign tmr_run[1] = (state_reg == ST_DEAD);                        // [RULE23]
    assign tmr_run[2] = (state_reg == ST_CLOSE) & !init_lvl;           // [RULE22]
    assign tmr_run[3] = (state_reg == ST_CLOSE) & (seq == `ARC_SEQ_1THEN2) &
                        !xfer_done_reg & !init_lvl;                    // [RULE6]
    assign tmr_set = {{1'b0, set_reg[`ARC_SET_TRANSFER]},
                      {1'b0, set_reg[`ARC_SET_RESET]},
                      {1'b0, set_reg[`ARC_SET_INCOMPLETE]}, dead_set};

    arc_tick #(
        .PERIOD (TICK_CYCLES)
    ) u_tick (
        .mclk (mclk),
        .rst  (rst),
        .tick (tick)
    );

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_tmr
            arc_timer u_tmr (
                .mclk    (mclk),
                .rst     (rst),
                .tick    (tick),                                       // [RULE25]
                .run     (tmr_run[g]),
                .setting (tmr_set[g*17+16:g*17]),
                .expired (tmr_exp[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer state machine
    reg  [2:0] fs;
    wire       bkr_ok = (!(seq != `ARC_SEQ_BKR2) | bkr1_s) & (!(seq != `ARC_SEQ_BKR1) | bkr2_s);

    always @* begin
        state_next = state_reg;
        sel_next   = sel_reg;
        shot_next  = shot_reg;
        fs         = first_shot(prog, sp_s, tp_s, dtp_s, mp_s);
        case (state_reg)
            ST_DISABLED: begin
                shot_next = 2'h0;
                if (enable) state_next = ST_RESET;
            end
            ST_RESET: begin
                shot_next = 2'h0;                                      // [RULE11]
                if (init_edge) begin
                    sel_next   = fs[1:0];
                    state_next = fs[2] ? ST_LOCKOUT : ST_DEAD;         // [RULE12]
                end
            end
            ST_DEAD: begin
                if (blk_s || tmr_exp[1]) begin
                    state_next = ST_LOCKOUT;                           // [RULE23]
                end else if (tmr_exp[0]) begin
                    state_next = ST_CLOSE;
                    shot_next  = shot_reg + 2'h1;
                end
            end
            ST_CLOSE: begin
                if (blk_s) begin
                    state_next = ST_LOCKOUT;
                end else if (init_edge) begin
                    if (shot_reg >= shot_lim)
                        state_next = ST_LOCKOUT;                       // [RULE14]
                    else if (prog == `ARC_PROG_3POLE_A && mp_s)
                        state_next = ST_LOCKOUT;
                    else begin
                        state_next = ST_DEAD;
                        sel_next   = SEL_D2;                           // [RULE3]
                    end
                end else if (tmr_exp[2]) begin
                    state_next = bkr_ok ? ST_RESET : ST_LOCKOUT;       // [RULE22]
                end
            end
            ST_LOCKOUT: begin
                if (rstin_s) state_next = ST_RESET;                    // [RULE13]
            end
            default: begin
                state_next = ST_DISABLED;
            end
        endcase
        if (!enable) state_next = ST_DISABLED;                         // [RULE10]
    end

    assign reclose_in_progress = (state_reg == ST_DEAD);               // [RULE20]
    assign lockout_state       = (state_reg == ST_LOCKOUT);

    wire enter_close = (state_reg == ST_DEAD) && (state_next == ST_CLOSE);
    wire idle_next   = (state_next == ST_RESET) || (state_next == ST_LOCKOUT) ||
                       (state_next == ST_DISABLED);
    wire force_hit   = (state_reg == ST_DEAD) && (sel_reg == SEL_SP) &&
                       (force_cnt_reg == FORCE_LAST);

    always @(posedge mclk) begin
        if (rst) begin
            state_reg             <= ST_DISABLED;
            sel_reg               <= SEL_SP;
            shot_reg              <= 2'h0;
            init_prev_reg         <= 1'b0;
            ext_reg               <= 1'b0;
            xfer_done_reg         <= 1'b0;
            force_latch_reg       <= 1'b0;
            force_cnt_reg         <= 20'h0_0000;
            force_three_pole_trip <= 1'b0;
            close_breaker_one_cmd <= 1'b0;
            close_breaker_two_cmd <= 1'b0;
        end else begin
            state_reg     <= state_next;
            sel_reg       <= sel_next;
            shot_reg      <= shot_next;
            init_prev_reg <= init_lvl;
            if (state_reg != ST_DEAD)
                ext_reg <= 1'b0;
            else if (shot_reg == 2'h0 && ext_s)
                ext_reg <= 1'b1;                                       // [RULE24]
            if (state_reg == ST_DEAD && sel_reg == SEL_SP && !force_latch_reg)
                force_cnt_reg <= force_cnt_reg + 20'h0_0001;
            else
                force_cnt_reg <= 20'h0_0000;
            if (idle_next)
                force_latch_reg <= 1'b0;
            else if (force_hit)
                force_latch_reg <= 1'b1;                               // [RULE21]
            force_three_pole_trip <= enable & (force_latch_reg | force_hit |
                                     prog == `ARC_PROG_3POLE_A |
                                     prog == `ARC_PROG_3POLE_B |      // [RULE15]
                                     (shot_reg != 2'h0 && !idle_next));
            if (state_next != ST_CLOSE)
                close_breaker_one_cmd <= 1'b0;
            else if (enter_close)
                close_breaker_one_cmd <= (seq != `ARC_SEQ_BKR2);        // [RULE6]
            else if (bkr1_s)
                close_breaker_one_cmd <= 1'b0;
            if (state_next != ST_CLOSE)
                xfer_done_reg <= 1'b0;
            else if (tmr_exp[3])
                xfer_done_reg <= 1'b1;
            if (state_next != ST_CLOSE)
                close_breaker_two_cmd <= 1'b0;
            else if (enter_close)
                close_breaker_two_cmd <= (seq == `ARC_SEQ_BKR2) | (seq == `ARC_SEQ_BOTH);
            else if (tmr_exp[3] && !xfer_done_reg)
                close_breaker_two_cmd <= 1'b1;                         // [RULE6]
            else if (bkr2_s)
                close_breaker_two_cmd <= 1'b0;
        end
    end
endmodule // arc_sequencer

// ---- arc_sequencer_tb_top.sv ----
// Purpose: Bench for the autoreclose sequencer
// Assumes: 10-cycle tick, settings in ticks
// Notes:   Checks via queues
`timescale 1ns/1ps
`include "arc_regs.vh"
`define CHK(n, e, g) begin checks_done++; ce = (e); cg = (g); if (cg !== ce) begin \
    err_total++; $display("ERROR %s exp %h got %h", n, ce, cg); end end
module arc_sequencer_tb_top;
    logic        mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, mp = 0, ext = 0, rin = 0;
    logic [7:0]  reg_addr = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, e, m, ce, cg, q_exp[$], q_msk[$];
    logic [2:0]  init = 0;
    logic [3:0]  dly = 1;
    logic [1:0]  trip = 0, tr, bc, cmd, cmd_d = 0, q_cmd[$];
    int          err_total = 0, checks_done = 0, seed = 51, i, s;
    int          pg[10] = '{0, 0, 0, 1, 1, 2, 2, 3, 3, 3};
    int          kd[10] = '{0, 1, 2, 0, 1, 1, 1, 1, 2, 1};
    int          fm[10] = '{0, 1, 1, 0, 1, 0, 1, 1, 1, 0};
    int          dt[10] = '{3, 2, 4, 3, 0, 2, 0, 2, 4, 5};
    int          sv[7] = '{3, 2, 4, 3, 6, 50, 3};
    logic [15:0] dv[7] = '{`ARC_RST_SP_DEAD, `ARC_RST_DEAD1, `ARC_RST_DEAD2, `ARC_RST_EXTEND,
                           `ARC_RST_RESET, `ARC_RST_INCOMPLETE, `ARC_RST_TRANSFER};
    arc_sequencer #(.TICK_CYCLES(10), .FORCE_CYCLES(8)) i_dut (.mclk, .rst, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .single_pole_initiate(init[0]),
        .three_pole_initiate(init[1]), .delayed_three_pole_initiate(init[2]),
        .multiphase_fault_input(mp), .dead_time_extension_input(ext), .reset_input(rin),
        .breaker_closed_input(bc[0]), .breaker_two_closed_input(bc[1]),
        .scheme_block_input(1'b0), .reclose_in_progress(), .force_three_pole_trip(),
        .close_breaker_one_cmd(cmd[0]), .close_breaker_two_cmd(cmd[1]), .lockout_state());
    arc_breaker_model i_bkr (.mclk, .rst, .trip, .cls(cmd), .dly, .closed(bc));
    initial forever #5 mclk = ~mclk;
    task end_of_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] ex, mk);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        q_exp.push_back(ex);
        q_msk.push_back(mk);
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask
    // Fault with initiate held, then status in dead time and in close; for d below 1 one status read, lockout or disabled
    task shot(input int k, f, d, fx, input logic [1:0] trp);
        @(posedge mclk);
        init <= 3'h1 << k;
        mp <= f;
        trip <= trp;
        dly <= 4'(1 + {$random(seed)} % 8);
        repeat (8 + (d > 1 ? (d - 2) * 10 : 0)) @(posedge mclk);
        init <= 3'h0;
        trip <= 2'h0;
        if (d < 1) rd(`ARC_OFS_STATUS, d ? 32'h0000_0000 : 32'h0000_1004, 32'h0000_1107);
        else begin
            rd(`ARC_OFS_STATUS, 32'h0000_0102 | fx << 9, 32'h0000_0107 | fx << 9);
            repeat (13) @(posedge mclk);
            rd(`ARC_OFS_STATUS, 32'h0000_0003, 32'h0000_0107);
        end
    endtask
    task settle(input int f);
        repeat (80) @(posedge mclk);
        rd(`ARC_OFS_STATUS, 32'h0000_0001 | f << 9, 32'h0000_0337);
    endtask
    task clr;
        @(posedge mclk);
        rin <= 1'b1;
        repeat (4) @(posedge mclk);
        rin <= 1'b0;
        rd(`ARC_OFS_STATUS, 32'h0000_0001, 32'h0000_1107);
    endtask
    ////////////////////////////////////////////////////////////
    always @(posedge mclk) begin
        rd_d <= reg_rd;
        cmd_d <= cmd;
        if (rd_d) begin
            e = q_exp.pop_front();
            m = q_msk.pop_front();
            `CHK("reg_rdata", e & m, reg_rdata & m)
        end
        if ((cmd & ~cmd_d) != 2'h0) `CHK("close_cmd", q_cmd.pop_front(), cmd & ~cmd_d)
    end
    initial begin
        repeat (30000) @(posedge mclk);
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(`ARC_OFS_CTRL, 32'h0000_0008, '1);
        for (i = 0; i < 7; i++) rd(8'(`ARC_OFS_SET_BASE + 4 * i), dv[i], '1);
        rd(8'h24, 32'h0000_0000, '1);
        wr(`ARC_OFS_STATUS, '1);
        rd(`ARC_OFS_STATUS, 32'h0000_0000, '1);
        for (i = 0; i < 7; i++) begin
            wr(8'(`ARC_OFS_SET_BASE + 4 * i), {16'($random(seed)), 16'(sv[i])});
            rd(8'(`ARC_OFS_SET_BASE + 4 * i), sv[i], '1);
        end
        shot(0, 0, -1, 0, 2'h1);
        for (i = 0; i < 10; i++) begin
            s = i % 4;
            tr = s == 0 ? 2'h1 : s == 1 ? 2'h2 : 2'h3;
            wr(`ARC_OFS_CTRL, 32'h0000_0009 | pg[i] << 1 | s << 4);
            ext <= (i == 9);
            if (dt[i]) q_cmd.push_back(s == 3 ? 2'h1 : tr);
            if (dt[i] && s == 3) q_cmd.push_back(2'h2);
            shot(kd[i], fm[i], dt[i], pg[i] > 1 || kd[i] == 0, tr);
            if (dt[i]) settle(pg[i] > 1);
            else clr();
        end
        wr(`ARC_OFS_CTRL, 32'h0000_0007);
        q_cmd.push_back(2'h1);
        shot(1, 0, 5, 1, 2'h1);
        shot(1, 0, 0, 1, 2'h1);
        shot(1, 0, 0, 1, 2'h1);
        clr();
        wr(`ARC_OFS_CTRL, 32'h0000_000f);
        q_cmd = '{2'h1, 2'h1};
        shot(1, 0, 5, 1, 2'h1);
        shot(1, 0, 4, 1, 2'h1);
        shot(1, 0, 0, 1, 2'h1);
        clr();
        repeat (3) @(posedge mclk);
        `CHK("cmds_left", 0, q_cmd.size())
        end_of_test();
    end
endmodule // arc_sequencer_tb_top

// ---- arc_tick.v ----
// Purpose: Common 10 ms timebase pulse
// Assumes: PERIOD below 2**20
// Notes:   One-cycle pulse every PERIOD clocks
`timescale 1ns/1ps

module arc_tick #(
    parameter PERIOD = 1000000
) (
    input  wire mclk,
    input  wire rst,
    output reg  tick
);
    localparam [19:0] LAST = PERIOD[19:0] - 20'h0_0001;

    reg [19:0] cnt_reg;

    always @(posedge mclk) begin
        if (rst) begin
            cnt_reg <= 20'h0_0000;
            tick    <= 1'b0;
        end else if (cnt_reg == LAST) begin
            cnt_reg <= 20'h0_0000;
            tick    <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 20'h0_0001;
            tick    <= 1'b0;
        end
    end
endmodule // arc_tick

// ---- arc_timer.v ----
// Purpose: Tick-counting timer with programmable setting
// Assumes: tick is a one-cycle pulse
// Notes:   Cleared while run is low; expired once count reaches setting
`timescale 1ns/1ps

module arc_timer (
    input  wire        mclk,
    input  wire        rst,
    input  wire        tick,
    input  wire        run,
    input  wire [16:0] setting,
    output wire        expired
);
    reg [16:0] count_reg;

    assign expired = run & (count_reg >= setting);

    always @(posedge mclk) begin
        if (rst || !run) begin
            count_reg <= 17'h0_0000;
        end else if (tick && !expired) begin
            count_reg <= count_reg + 17'h0_0001;
        end
    end
endmodule // arc_timer
